// ==== rtl/mqx_pkg.sv ====
package mqx_pkg;
    // address layout: top three bits pick the device, low bits the queue
    localparam int WR_ADDR_W = 5;
    localparam int RD_ADDR_W = 6;
    localparam int DEV_CODE_W = 3;
    localparam int QSEL_W = 2;
    localparam int NUM_QUEUES = 4;
    localparam int RD_NULL_BIT = 2;
    // data bus widths picked by the width selects
    localparam int BUS_WIDE = 18;
    localparam int BUS_NARROW = 9;
    // output valid lags the read selection by this many cycles
    localparam int OV_LAG_CYCLES = 2;
    // register byte offsets on the wishbone bus
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_SEL = 8'h08;
    // control register field positions and reset value
    localparam int CTRL_PROG_DONE = 0;
    localparam logic CTRL_PROG_DONE_RST = 1'b0;
    // config register field positions
    localparam int CFG_CODE_LSB = 0;
    localparam int CFG_IN_X9 = 3;
    localparam int CFG_OUT_X9 = 4;
    localparam int CFG_PRIMARY = 5;
    localparam int CFG_POLLED = 6;
    localparam int CFG_VALID = 7;
    // selection register field positions
    localparam int SEL_WR = 0;
    localparam int SEL_WR_Q = 1;
    localparam int SEL_RD = 3;
    localparam int SEL_RD_Q = 4;
    localparam int SEL_RD_NULL = 6;
    localparam int SEL_OV_N = 7;
    localparam int SEL_AF_OWN = 8;
    // number of synchronised pin bits
    localparam int PIN_BITS = 24;
endpackage

// ==== rtl/mqx_expansion_config.sv ====
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module mqx_expansion_config
    import mqx_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // configuration pins and master reset
    input wire logic global_reset_n_in,
    input wire logic [DEV_CODE_W-1:0] device_select_code_in,
    input wire logic input_width_select_in,
    input wire logic output_width_select_in,
    input wire logic primary_select_in,
    input wire logic flag_mode_select_in,
    // write port selection
    input wire logic write_select_strobe_in,
    input wire logic flag_bus_strobe_in,
    input wire logic [WR_ADDR_W-1:0] write_queue_address_in,
    // read port selection and output enable
    input wire logic read_select_strobe_in,
    input wire logic [RD_ADDR_W-1:0] read_queue_address_in,
    input wire logic output_enable_n_in,
    // queue status from the local queue logic
    input wire logic [NUM_QUEUES-1:0] almost_full_flag_in,
    input wire logic [NUM_QUEUES-1:0] queue_empty_in,
    // almost-full flag bus and token chain
    input wire logic full_token_in,
    output logic full_token_out,
    output logic full_poll_sync_pulse_out,
    output logic [NUM_QUEUES-1:0] almost_full_flag_bus_out,
    output logic almost_full_flag_bus_oe_out,
    // write side state
    output logic write_selected_out,
    output logic [QSEL_W-1:0] write_queue_out,
    output logic write_bus_x9_out,
    // read side state and shared outputs
    output logic read_selected_out,
    output logic [QSEL_W-1:0] read_queue_out,
    output logic read_bus_x9_out,
    output logic read_data_oe_out,
    output logic output_valid_flag_n_out,
    output logic output_valid_flag_oe_out
);
    logic [PIN_BITS-1:0] pin_s1_r;
    logic [PIN_BITS-1:0] pin_s2_r;
    logic mrs_s, tok_s, fstr_s, wstr_s, rstr_s, oe_n_s;
    logic iw_s, ow_s, prim_s, fm_s;
    logic [DEV_CODE_W-1:0] code_s;
    logic [WR_ADDR_W-1:0] waddr_s;
    logic [RD_ADDR_W-1:0] raddr_s;
    logic mrs_d_r;
    logic cfg_valid_r, cfg_iw_r, cfg_ow_r, cfg_prim_r, cfg_fm_r;
    logic [DEV_CODE_W-1:0] cfg_code_r;
    logic prog_done_r, ready, ready_d_r, kick;
    logic mrs_fall, mrs_rise;
    logic wr_match, rd_match, poll_load;
    logic wr_sel_r, rd_sel_r, rd_null_r, rd_own_r, af_own_r;
    logic [QSEL_W-1:0] wr_q_r, rd_q_r;
    logic sync_r, tok_r, af_oe_r;
    logic [NUM_QUEUES-1:0] af_bus_r;
    logic rd_has_data, ov_p1_r, ov_n_r;
    logic ack_r;
    logic [31:0] rdata, dat_r;

    // queue bits must sit right below the device code; on the read bus the null bit sits between them
    if (WR_ADDR_W != DEV_CODE_W + QSEL_W || NUM_QUEUES != (1 << QSEL_W)
        || RD_ADDR_W != RD_NULL_BIT + 1 + DEV_CODE_W) begin : g_addr_check
        $error("address layout does not fit the code and queue fields");
    end

    // every pin crosses two flops; stage one feeds stage two only
    always_ff @(posedge clk_in) begin
        pin_s1_r <= {global_reset_n_in, device_select_code_in, input_width_select_in,
                     output_width_select_in, primary_select_in, flag_mode_select_in,
                     full_token_in, flag_bus_strobe_in, write_select_strobe_in,
                     write_queue_address_in, read_select_strobe_in,
                     read_queue_address_in, output_enable_n_in};
        pin_s2_r <= pin_s1_r;
    end

    // unpack the synchronised pins
    assign {mrs_s, code_s, iw_s, ow_s, prim_s, fm_s, tok_s, fstr_s, wstr_s,
            waddr_s, rstr_s, raddr_s, oe_n_s} = pin_s2_r;

    // master reset edges; history starts high so a full pulse is needed
    assign mrs_fall = mrs_d_r && !mrs_s;
    assign mrs_rise = !mrs_d_r && mrs_s;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mrs_d_r <= 1'b1;
        end else begin
            mrs_d_r <= mrs_s;
        end
    end

    // straps caught at the release of master reset, frozen until the next one
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cfg_valid_r <= 1'b0;
            cfg_code_r <= '0;
            cfg_iw_r <= 1'b0;
            cfg_ow_r <= 1'b0;
            cfg_prim_r <= 1'b0;
            cfg_fm_r <= 1'b0;
        end else if (mrs_fall) begin
            cfg_valid_r <= 1'b0;
        end else if (mrs_rise) begin
            cfg_valid_r <= 1'b1;
            cfg_code_r <= code_s;
            cfg_iw_r <= iw_s;
            cfg_ow_r <= ow_s;
            cfg_prim_r <= prim_s;
            cfg_fm_r <= fm_s;
        end
    end

    // programming flag: software sets it, master reset clears it
    always_ff @(posedge clk_in) begin
        if (srst_in || mrs_fall) begin
            prog_done_r <= CTRL_PROG_DONE_RST;
        end else if (ack_r && wb_we_in && wb_sel_in[0] && wb_adr_in == REG_CTRL) begin
            prog_done_r <= wb_dat_in[CTRL_PROG_DONE];
        end
    end

    // selections are refused until configured and programmed
    assign ready = cfg_valid_r && prog_done_r && mrs_s;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ready_d_r <= 1'b0;
        end else begin
            ready_d_r <= ready;
        end
    end

    // the primary opens the polling loop once, as it becomes ready
    assign kick = ready && !ready_d_r && cfg_prim_r;

    // device match on the top address bits; the role plays no part
    assign wr_match = waddr_s[WR_ADDR_W-1 -: DEV_CODE_W] == cfg_code_r;
    assign rd_match = raddr_s[RD_ADDR_W-1 -: DEV_CODE_W] == cfg_code_r;

    // write queue selection
    always_ff @(posedge clk_in) begin
        if (srst_in || !ready) begin
            wr_sel_r <= 1'b0;
            wr_q_r <= '0;
        end else if (wstr_s) begin
            wr_sel_r <= wr_match;
            wr_q_r <= waddr_s[QSEL_W-1:0];
        end
    end

    // read queue selection; bit two addresses the null queue
    always_ff @(posedge clk_in) begin
        if (srst_in || !ready) begin
            rd_sel_r <= 1'b0;
            rd_null_r <= 1'b0;
            rd_q_r <= '0;
        end else if (rstr_s) begin
            rd_sel_r <= rd_match;
            rd_null_r <= raddr_s[RD_NULL_BIT];
            rd_q_r <= raddr_s[QSEL_W-1:0];
        end
    end

    // ownership of the read-side shared lines: primary first, then by selection
    always_ff @(posedge clk_in) begin
        if (srst_in || !cfg_valid_r) begin
            rd_own_r <= 1'b0;
        end else if (!ready_d_r) begin
            rd_own_r <= cfg_prim_r;
        end else if (rstr_s && ready) begin
            rd_own_r <= rd_match;
        end
    end

    // direct flag bus: a strobe with matching code hands this device the bus
    always_ff @(posedge clk_in) begin
        if (srst_in || !cfg_valid_r || cfg_fm_r) begin
            af_own_r <= 1'b0;
        end else if (!ready_d_r) begin
            af_own_r <= cfg_prim_r;
        end else if (fstr_s && ready) begin
            af_own_r <= wr_match;
        end
    end

    // polled flag bus: our slot is the edge after the token arrives
    assign poll_load = cfg_fm_r && ready && (tok_s || kick);
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sync_r <= 1'b0;
            tok_r <= 1'b0;
            af_oe_r <= 1'b0;
            af_bus_r <= '0;
        end else begin
            sync_r <= poll_load;
            tok_r <= poll_load;
            af_oe_r <= poll_load || (!cfg_fm_r && af_own_r && ready);
            af_bus_r <= almost_full_flag_in;
        end
    end

    // output valid: two-stage path matching the data output delay
    assign rd_has_data = rd_sel_r && !rd_null_r && !queue_empty_in[rd_q_r];
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ov_p1_r <= 1'b0;
            ov_n_r <= 1'b1;
        end else begin
            ov_p1_r <= rd_has_data;
            ov_n_r <= !ov_p1_r;
        end
    end

    // output enable is a pin, so it reaches the lines after synchronising
    assign read_data_oe_out = cfg_valid_r && !oe_n_s
                              && (cfg_prim_r || rd_own_r);
    assign output_valid_flag_oe_out = cfg_valid_r && rd_own_r;

    // flag bus, token and output valid flag outputs
    assign full_poll_sync_pulse_out = sync_r;
    assign full_token_out = tok_r;
    assign almost_full_flag_bus_out = af_bus_r;
    assign almost_full_flag_bus_oe_out = af_oe_r;
    assign output_valid_flag_n_out = ov_n_r;

    // selection and width state
    assign write_selected_out = wr_sel_r;
    assign write_queue_out = wr_q_r;
    assign read_selected_out = rd_sel_r;
    assign read_queue_out = rd_q_r;
    assign write_bus_x9_out = cfg_iw_r;
    assign read_bus_x9_out = cfg_ow_r;

    // register read mux; unmapped offsets read zero
    always_comb begin
        rdata = '0;
        case (wb_adr_in)
            REG_CTRL: begin
                rdata[CTRL_PROG_DONE] = prog_done_r;
            end
            REG_CFG: begin
                rdata[CFG_CODE_LSB +: DEV_CODE_W] = cfg_code_r;
                rdata[CFG_IN_X9] = cfg_iw_r;
                rdata[CFG_OUT_X9] = cfg_ow_r;
                rdata[CFG_PRIMARY] = cfg_prim_r;
                rdata[CFG_POLLED] = cfg_fm_r;
                rdata[CFG_VALID] = cfg_valid_r;
            end
            REG_SEL: begin
                rdata[SEL_WR] = wr_sel_r;
                rdata[SEL_WR_Q +: QSEL_W] = wr_q_r;
                rdata[SEL_RD] = rd_sel_r;
                rdata[SEL_RD_Q +: QSEL_W] = rd_q_r;
                rdata[SEL_RD_NULL] = rd_null_r;
                rdata[SEL_OV_N] = ov_n_r;
                rdata[SEL_AF_OWN] = af_own_r;
            end
            default: begin
                rdata = '0;
            end
        endcase
    end

    // one wait state: ack one cycle after the request, dropped right after
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= wb_cyc_in && wb_stb_in && !ack_r;
            if (wb_cyc_in && wb_stb_in && !ack_r) begin
                dat_r <= rdata;
            end
        end
    end
    assign wb_ack_out = ack_r;
    assign wb_dat_out = dat_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence s_token_seen;
        cfg_fm_r && ready && tok_s;
    endsequence
    sequence s_queue_full2;
        rd_has_data ##1 rd_has_data;
    endsequence
    sequence s_queue_empty2;
        !rd_has_data ##1 !rd_has_data;
    endsequence
    sequence s_rd_pick;
        rstr_s && ready && rd_match;
    endsequence

    a_sync_with_bus: assert property (sync_r |-> af_oe_r && tok_r)
        else $error("sync pulse without own status on the bus");
    a_token_loads: assert property (s_token_seen |=> sync_r && af_oe_r)
        else $error("token did not load status at the next edge");
    a_token_pulse: assert property (tok_r |-> sync_r && cfg_fm_r)
        else $error("token out pulsed outside own polled slot");
    a_poll_one_slot: assert property (cfg_fm_r && af_oe_r |-> sync_r)
        else $error("polled bus driven outside own slot");
    a_wr_mismatch: assert property (wstr_s && ready && !wr_match |=> !wr_sel_r)
        else $error("write selection taken on foreign device code");
    a_rd_select: assert property (s_rd_pick |=> rd_sel_r && rd_q_r == $past(raddr_s[1:0]))
        else $error("read queue selection not taken");
    a_ov_valid_lag: assert property (s_queue_full2 |=> !ov_n_r)
        else $error("output valid not low two cycles after data");
    a_ov_empty: assert property (s_queue_empty2 |=> ov_n_r)
        else $error("output valid not high after read to empty");
    a_cfg_capture: assert property (mrs_rise |=> cfg_valid_r && cfg_code_r == $past(code_s)
        && cfg_prim_r == $past(prim_s) && cfg_fm_r == $past(fm_s))
        else $error("configuration not captured at reset release");
    a_cfg_hold: assert property (cfg_valid_r && !mrs_fall |=> $stable(cfg_code_r)
        && $stable(cfg_iw_r) && $stable(cfg_ow_r) && $stable(cfg_prim_r))
        else $error("configuration changed outside master reset");
    a_mrs_unconfig: assert property (mrs_fall |=> !cfg_valid_r && !prog_done_r)
        else $error("master reset did not drop configuration");
    a_widths: assert property (write_bus_x9_out == cfg_iw_r
        && read_bus_x9_out == cfg_ow_r)
        else $error("bus width outputs disagree with captured straps");
    a_primary_oe: assert property (cfg_valid_r && cfg_prim_r
        |-> read_data_oe_out == !oe_n_s)
        else $error("primary data enable does not follow output enable");
    a_secondary_off: assert property (!cfg_prim_r && !rd_own_r
        |-> !read_data_oe_out && !output_valid_flag_oe_out)
        else $error("secondary drives before being read-selected");
    a_primary_first: assert property ($rose(ready_d_r) && !cfg_prim_r && !cfg_fm_r
        |-> !af_own_r && !rd_own_r)
        else $error("secondary took shared outputs after reset");
    a_direct_no_sync: assert property (!cfg_fm_r |=> !sync_r)
        else $error("sync pulse in direct flag mode");
    a_direct_release: assert property (!cfg_fm_r && !af_own_r |=> !af_oe_r)
        else $error("flag bus driven by a device that does not own it");
endmodule

// ==== tb/mqx_peer_model.sv ====
`timescale 1ns/1ps
// far side of a single device: token wiring and a local queue status source
module mqx_peer_model
    import mqx_pkg::*;
(
    // clock
    input wire logic clk_in,
    // system wiring choice and token from the device
    input wire logic polled_in,
    input wire logic full_token_out_in,
    // towards the device
    output logic full_token_in_out,
    output logic [NUM_QUEUES-1:0] almost_full_flag_out
);
    logic [NUM_QUEUES-1:0] status_r = 4'h0;

    // single device: loop back in polled mode, hold low in direct mode
    assign full_token_in_out = polled_in ? full_token_out_in : 1'b0;

    // status changes every cycle so a stale copy on the flag bus is caught
    always_ff @(posedge clk_in) begin
        status_r <= status_r + 4'h3;
    end
    assign almost_full_flag_out = status_r;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import mqx_pkg::*;
    logic clk, srst, cyc, stb, we, gr_n, inw, outw, prim, fmode, wstb, fstb, rstb, oe_n;
    logic ack, tok_in, tok_out, full_poll_sync_pulse, af_oe, wsel, rsel, wx9, rx9, d_oe, ov_n, ov_oe;
    logic [3:0] sel, af, empty, af_bus, af_prev;
    logic [7:0] adr;
    logic [31:0] dat_w, dat_r, rd, r;
    logic [2:0] code, dcode;
    logic [4:0] waddr, wa;
    logic [5:0] raddr, ra;
    logic [1:0] wq, rq;
    int err_total, checks, seed, gap, pulses;

    mqx_expansion_config u_dut (
        .clk_in(clk), .srst_in(srst), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_sel_in(sel), .wb_adr_in(adr), .wb_dat_in(dat_w), .wb_dat_out(dat_r),
        .wb_ack_out(ack), .global_reset_n_in(gr_n), .device_select_code_in(code),
        .input_width_select_in(inw), .output_width_select_in(outw),
        .primary_select_in(prim), .flag_mode_select_in(fmode),
        .write_select_strobe_in(wstb), .flag_bus_strobe_in(fstb),
        .write_queue_address_in(waddr), .read_select_strobe_in(rstb),
        .read_queue_address_in(raddr), .output_enable_n_in(oe_n),
        .almost_full_flag_in(af), .queue_empty_in(empty), .full_token_in(tok_in),
        .full_token_out(tok_out), .full_poll_sync_pulse_out(full_poll_sync_pulse),
        .almost_full_flag_bus_out(af_bus), .almost_full_flag_bus_oe_out(af_oe),
        .write_selected_out(wsel), .write_queue_out(wq), .write_bus_x9_out(wx9),
        .read_selected_out(rsel), .read_queue_out(rq), .read_bus_x9_out(rx9),
        .read_data_oe_out(d_oe), .output_valid_flag_n_out(ov_n),
        .output_valid_flag_oe_out(ov_oe)
    );

    mqx_peer_model u_peer (
        .clk_in(clk), .polled_in(fmode), .full_token_out_in(tok_out),
        .full_token_in_out(tok_in), .almost_full_flag_out(af)
    );

    // free-running bench clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // classic single cycle; only the watchdog ends a wait for ack
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // master reset pulse with new straps, then programming
    task automatic mrst(input logic [2:0] c, input logic iw, ow, pr, pl);
        @(posedge clk);
        code <= c;
        inw <= iw;
        outw <= ow;
        prim <= pr;
        fmode <= pl;
        gr_n <= 1'b0;
        repeat (4) @(posedge clk);
        gr_n <= 1'b1;
        repeat (6) @(posedge clk);
        dcode = c;
        wb_xfer(1'b0, REG_CTRL, 32'h0);
        chk_word("ctrl_clr", 32'h0, rd);
        wb_xfer(1'b1, REG_CFG, 32'h0);
        wb_xfer(1'b0, REG_CFG, 32'h0);
        chk_word("cfg", {24'h0, 1'b1, pl, pr, ow, iw, c}, rd);
        wb_xfer(1'b1, REG_CTRL, 32'h1);
        wb_xfer(1'b0, REG_CTRL, 32'h0);
        chk_word("ctrl", 32'h1, rd);
        wb_xfer(1'b0, 8'h0c, 32'h0);
        chk_word("unmapped", 32'h0, rd);
        chk_bit("wx9", iw, wx9);
        chk_bit("rx9", ow, rx9);
    endtask

    // one-cycle strobes on both ports, selection 3 edges on, valid flag 2 more
    task automatic sel_pulse(input logic [5:0] a, input logic [4:0] b, input logic rdy);
        logic s, t;
        s = rdy & (a[5:3] == dcode);
        t = rdy & (b[4:2] == dcode);
        @(posedge clk);
        rstb <= 1'b1;
        wstb <= 1'b1;
        raddr <= a;
        waddr <= b;
        @(posedge clk);
        rstb <= 1'b0;
        wstb <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_bit("rsel", s, rsel);
        chk_bit("wsel", t, wsel);
        if (s) chk_word("rq", {30'h0, a[1:0]}, {30'h0, rq});
        if (t) chk_word("wq", {30'h0, b[1:0]}, {30'h0, wq});
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_bit("ov_n", !(s & !a[2] & !empty[a[1:0]]), ov_n);
    endtask

    // watchdog sized well above the few hundred cycles the sequence needs
    initial begin
        #400000;
        err_total++;
        complete_run();
    end

    initial begin
        {cyc, stb, we, wstb, fstb, rstb, inw, outw, fmode} = 9'h0;
        {srst, gr_n, oe_n, prim} = 4'hf;
        sel = 4'h0;
        adr = 8'h00;
        dat_w = 32'h0;
        code = 3'h0;
        dcode = 3'h0;
        waddr = 5'h00;
        raddr = 6'h00;
        empty = 4'h0;
        af_prev = 4'h0;
        seed = 31;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk_bit("ov_n_rst", 1'b1, ov_n);
        chk_bit("tok_rst", 1'b0, tok_out);
        sel_pulse(6'h00, 5'h00, 1'b0);
        mrst(3'h5, 1'b1, 1'b0, 1'b1, 1'b1);
        // polled single device: token loops back every third cycle
        pulses = 0;
        gap = 0;
        // seed the status history so the first slot compares against real data
        @(negedge clk);
        af_prev = af;
        repeat (40) begin
            @(negedge clk);
            chk_bit("sync", tok_out, full_poll_sync_pulse);
            chk_bit("bus_oe", tok_out, af_oe);
            if (tok_out === 1'b1) begin
                chk_word("af_bus", {28'h0, af_prev}, {28'h0, af_bus});
                if (pulses > 0) chk_word("gap", 32'h3, gap);
                pulses++;
                gap = 0;
            end
            gap++;
            af_prev = af;
        end
        chk_bit("polling", 1'b1, pulses > 8);
        @(posedge clk);
        oe_n <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_bit("d_oe_on", 1'b1, d_oe);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            @(posedge clk);
            empty <= r[11:8];
            ra = r[5:0];
            wa = r[16:12];
            if (i[0]) ra[5:3] = dcode;
            if (i[1]) wa[4:2] = dcode;
            sel_pulse(ra, wa, 1'b1);
        end
        @(posedge clk);
        oe_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_bit("d_oe_off", 1'b0, d_oe);
        mrst(3'h2, 1'b0, 1'b1, 1'b0, 1'b0);
        @(posedge clk);
        oe_n <= 1'b0;
        repeat (10) begin
            @(negedge clk);
            chk_bit("sync_direct", 1'b0, full_poll_sync_pulse);
        end
        chk_bit("d_oe_sec", 1'b0, d_oe);
        chk_bit("ov_oe_sec", 1'b0, ov_oe);
        chk_bit("af_oe_sec", 1'b0, af_oe);
        sel_pulse(6'h11, 5'h1f, 1'b1);
        chk_bit("d_oe_sel", 1'b1, d_oe);
        chk_bit("ov_oe_sel", 1'b1, ov_oe);
        sel_pulse(6'h39, 5'h08, 1'b1);
        chk_bit("d_oe_lost", 1'b0, d_oe);
        @(posedge clk);
        fstb <= 1'b1;
        @(posedge clk);
        fstb <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_bit("af_oe_direct", 1'b1, af_oe);
        @(posedge clk);
        code <= 3'h7;
        inw <= 1'b1;
        repeat (4) @(posedge clk);
        wb_xfer(1'b0, REG_CFG, 32'h0);
        chk_word("cfg_held", {24'h0, 8'h92}, rd);
        // lone device wired as the system must: code zero, primary, top address bits low
        mrst(3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
        chk_bit("af_oe_prim", 1'b1, af_oe);
        chk_bit("ov_oe_prim", 1'b1, ov_oe);
        chk_bit("d_oe_prim", 1'b1, d_oe);
        sel_pulse(6'h02, 5'h03, 1'b1);
        complete_run();
    end
endmodule
